/* hw/bcs_regs.svh */
// Constants of the battery charge supervisor: offsets, fields, resets, timing.
// Assumes 8-bit converter codes for the analog senses; higher code = hotter.
// Overview of operation
// - Watch id and thermistor senses for insertion.
// - Classify pack from id code windows.
// - Fast window is 10 to 40 degrees.
// - Valid pack in window: fast rate, red.
// - Outside window below 60: slow, red.
// - Fast ends at three hours or 45.
// - Final slow rate: red off, green on.
// - Radio present adds compensation current.
// - Transmit commands 1.5 amps, then restores.
// - Radio on when power sense near 7.5V.
// - Mic line picks family after power-on.
// - Open serial link in family protocol.
// - Linked radio hands over volume, monitor, push-to-talk.
// - Buttons step volume, five level lamps.
// - Either monitor button invokes monitor.
// - External mic button keys transmit.
// - Forward radio display text to mic.
// - Blink lowest lamp while on-channel.
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH
`define BCS_OFF_CTRL    8'h00
`define BCS_OFF_COMP    8'h04
`define BCS_OFF_STATUS  8'h08
`define BCS_OFF_CURRENT 8'h0c
`define BCS_CTRL_CHG_EN  0
`define BCS_CTRL_COMP_EN 1
`define BCS_CTRL_RESET  2'h3
`define BCS_COMP_RESET  12'h0c8
`define BCS_ID51_LO 8'h38
`define BCS_ID51_HI 8'h48
`define BCS_ID10_LO 8'h60
`define BCS_ID10_HI 8'h70
`define BCS_ID18_LO 8'h88
`define BCS_ID18_HI 8'h98
`define BCS_T10 8'h40
`define BCS_T40 8'h70
`define BCS_T45 8'h78
`define BCS_T60 8'h90
`define BCS_PWR_ON 8'hbf
`define BCS_FAST_MA 12'h320
`define BCS_SLOW_MA 12'h064
`define BCS_TX_MA   12'h5dc
`define BCS_HALF_SEC_NS 500000000
`define BCS_CLK_NS 10
`define BCS_FAST_SEC 10800
`define BCS_HELLO_A 8'ha1
`define BCS_HELLO_B 8'hb1
`define BCS_ACK     8'h5a
`define BCS_CMD_VOL 3'h1
`define BCS_CMD_MON 3'h2
`define BCS_CMD_PTT 3'h3
`define BCS_ST_RADIO 3'h4
`define BCS_RETRY_CYC 16'h2710
`endif

/* hw/bcs_pkg.sv */
// Types of the battery charge supervisor.
// Assumes bcs_regs.svh holds the design numbers; the state and class encodings stand here.
package bcs_pkg;
	typedef enum logic [4:0] {
		BCS_CH_IDLE = 5'h01,
		BCS_CH_SLOW = 5'h02,
		BCS_CH_FAST = 5'h04,
		BCS_CH_DONE = 5'h08,
		BCS_CH_OFF  = 5'h10
	} bcs_chg_t;
	typedef enum logic [3:0] {
		BCS_LK_OFF   = 4'h1,
		BCS_LK_SENSE = 4'h2,
		BCS_LK_HELLO = 4'h4,
		BCS_LK_UP    = 4'h8
	} bcs_link_t;
	typedef enum logic [1:0] {
		BCS_ID_NONE = 2'h0,
		BCS_ID_MED  = 2'h1,
		BCS_ID_HIGH = 2'h2,
		BCS_ID_UHI  = 2'h3
	} bcs_id_t;
	// Front-panel lamps.
	typedef struct packed {
		logic       red;
		logic       green;
		logic [4:0] vol;
	} bcs_ind_t;
	// Operator controls.
	typedef struct packed {
		logic vol_up;
		logic vol_down;
		logic mon_panel;
		logic mon_mic;
		logic ptt;
	} bcs_btn_t;
endpackage

/* hw/bcs_top.sv */
// Battery charge supervisor: charger control, radio sensing, serial link, AXI4-Lite.
// Assumes converted sense codes and button levels synchronous to clock_in.
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_top #(
	parameter int HALF_SEC_CYC = `BCS_HALF_SEC_NS / `BCS_CLK_NS,
	parameter int FAST_HALVES  = 2 * `BCS_FAST_SEC
) (
	// Clock and reset.
	input  wire logic              clock_in,
	input  wire logic              rst_n_in,
	// Analog senses as converter codes.
	input  wire logic [7:0]        id_code_in,
	input  wire logic [7:0]        temp_code_in,
	input  wire logic [7:0]        pwr_code_in,
	input  wire logic              mic_line_in,
	// Operator controls.
	input  wire bcs_pkg::bcs_btn_t btn_in,
	// Serial link to the radio processor.
	output logic                   link_tx_valid_out,
	output logic [7:0]             link_tx_data_out,
	input  wire logic              link_tx_ready_in,
	input  wire logic              link_rx_valid_in,
	input  wire logic [8:0]        link_rx_data_in,
	// Display microphone echo.
	output logic                   disp_valid_out,
	output logic [7:0]             disp_data_out,
	// Charger and lamps.
	output logic [11:0]            charge_ma_out,
	output bcs_pkg::bcs_ind_t      ind_out,
	// AXI4-Lite slave.
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// Pack class from the identification code window.
	function automatic bcs_pkg::bcs_id_t id_class(input logic [7:0] c);
		if (c >= `BCS_ID51_LO && c <= `BCS_ID51_HI) begin
			return bcs_pkg::BCS_ID_MED;
		end else if (c >= `BCS_ID10_LO && c <= `BCS_ID10_HI) begin
			return bcs_pkg::BCS_ID_HIGH;
		end else if (c >= `BCS_ID18_LO && c <= `BCS_ID18_HI) begin
			return bcs_pkg::BCS_ID_UHI;
		end
		return bcs_pkg::BCS_ID_NONE;
	endfunction

	bcs_pkg::bcs_chg_t  chg_q;
	bcs_pkg::bcs_link_t lk_q;
	bcs_pkg::bcs_id_t   id_now;
	logic        in_win, too_hot, fast_hot, chg_ok, radio_on;
	logic [31:0] tick_q;
	logic        half_q, blink_q;
	logic [15:0] fast_q;
	logic [1:0]  ctrl_q;
	logic [11:0] comp_q;
	logic        family_q, rx_tx_q, rx_on_q;
	logic [15:0] retry_q;
	logic [2:0]  vol_q, sent_vol_q;
	logic        sent_mon_q, sent_ptt_q, mon_now, up_q, dn_q;

	// Senses decoded every cycle so insertion and removal are seen at once.
	assign id_now   = id_class(id_code_in);
	assign in_win   = temp_code_in >= `BCS_T10 && temp_code_in <= `BCS_T40;
	assign fast_hot = temp_code_in >= `BCS_T45;
	assign too_hot  = temp_code_in >= `BCS_T60;
	assign chg_ok   = id_now != bcs_pkg::BCS_ID_NONE && !too_hot && ctrl_q[`BCS_CTRL_CHG_EN];
	assign radio_on = pwr_code_in >= `BCS_PWR_ON;
	assign mon_now  = btn_in.mon_panel | btn_in.mon_mic;

	// Half-second tick drives both the fast-charge timer and the blink.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			tick_q  <= 32'h0;
			half_q  <= 1'b0;
			blink_q <= 1'b0;
		end else begin
			half_q <= tick_q == 32'(HALF_SEC_CYC - 1);
			if (tick_q == 32'(HALF_SEC_CYC - 1)) begin
				tick_q  <= 32'h0;
				blink_q <= ~blink_q;
			end else begin
				tick_q <= tick_q + 32'h1;
			end
		end
	end

	// Charge state machine; removal always wins, overheat wins in all but BCS_CH_DONE.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			chg_q  <= bcs_pkg::BCS_CH_IDLE;
			fast_q <= 16'h0;
		end else begin
			case (chg_q)
				bcs_pkg::BCS_CH_IDLE, bcs_pkg::BCS_CH_OFF: begin
					fast_q <= 16'h0;
					if (chg_ok) begin
						chg_q <= in_win ? bcs_pkg::BCS_CH_FAST : bcs_pkg::BCS_CH_SLOW;
					end else begin
						chg_q <= bcs_pkg::BCS_CH_OFF;
					end
				end
				bcs_pkg::BCS_CH_SLOW: begin
					if (!chg_ok) begin
						chg_q <= bcs_pkg::BCS_CH_OFF;
					end else if (in_win) begin
						chg_q <= bcs_pkg::BCS_CH_FAST;
					end
				end
				bcs_pkg::BCS_CH_FAST: begin
					if (half_q) begin
						fast_q <= fast_q + 16'h1;
					end
					if (!chg_ok) begin
						chg_q <= bcs_pkg::BCS_CH_OFF;
					end else if (fast_hot || fast_q >= 16'(FAST_HALVES)) begin
						chg_q <= bcs_pkg::BCS_CH_DONE;
					end
				end
				bcs_pkg::BCS_CH_DONE: begin
					// Held until the pack leaves; a hot pack only pauses current and the green lamp.
					if (id_now == bcs_pkg::BCS_ID_NONE) begin
						chg_q <= bcs_pkg::BCS_CH_OFF;
					end
				end
				default: chg_q <= bcs_pkg::BCS_CH_IDLE;
			endcase
		end
	end

	// Commanded current and charge lamps, registered.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			charge_ma_out <= 12'h0;
			ind_out.red   <= 1'b0;
			ind_out.green <= 1'b0;
		end else begin
			// Gated by chg_ok so the lamp drops in the same cycle as the current.
			ind_out.red   <= (chg_q == bcs_pkg::BCS_CH_FAST || chg_q == bcs_pkg::BCS_CH_SLOW)
				&& chg_ok;
			ind_out.green <= chg_q == bcs_pkg::BCS_CH_DONE && !too_hot;
			if (!chg_ok || chg_q == bcs_pkg::BCS_CH_OFF || chg_q == bcs_pkg::BCS_CH_IDLE) begin
				charge_ma_out <= 12'h0;
			end else if (radio_on && rx_tx_q) begin
				charge_ma_out <= `BCS_TX_MA;
			end else begin
				charge_ma_out <= (chg_q == bcs_pkg::BCS_CH_FAST ? `BCS_FAST_MA : `BCS_SLOW_MA)
					+ ((radio_on && ctrl_q[`BCS_CTRL_COMP_EN]) ? comp_q : 12'h0);
			end
		end
	end

	// Link bring-up: sense family, say hello, wait for the answer.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			lk_q     <= bcs_pkg::BCS_LK_OFF;
			family_q <= 1'b0;
			retry_q  <= 16'h0;
		end else if (!radio_on) begin
			lk_q <= bcs_pkg::BCS_LK_OFF;
		end else begin
			case (lk_q)
				bcs_pkg::BCS_LK_OFF: lk_q <= bcs_pkg::BCS_LK_SENSE;
				bcs_pkg::BCS_LK_SENSE: begin
					family_q <= mic_line_in;
					retry_q  <= 16'h0;
					lk_q     <= bcs_pkg::BCS_LK_HELLO;
				end
				bcs_pkg::BCS_LK_HELLO: begin
					// A silent radio is greeted again after the retry time.
					retry_q <= retry_q == `BCS_RETRY_CYC ? 16'h0 : retry_q + 16'h1;
					if (link_rx_valid_in && link_rx_data_in == {1'b0, `BCS_ACK}) begin
						lk_q <= bcs_pkg::BCS_LK_UP;
					end
				end
				bcs_pkg::BCS_LK_UP: lk_q <= bcs_pkg::BCS_LK_UP;
				default: lk_q <= bcs_pkg::BCS_LK_OFF;
			endcase
		end
	end

	// Radio status words and display echo.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rx_tx_q        <= 1'b0;
			rx_on_q        <= 1'b0;
			disp_valid_out <= 1'b0;
			disp_data_out  <= 8'h0;
		end else begin
			disp_valid_out <= 1'b0;
			if (lk_q != bcs_pkg::BCS_LK_UP) begin
				rx_tx_q <= 1'b0;
				rx_on_q <= 1'b0;
			end else if (link_rx_valid_in && link_rx_data_in[8]) begin
				disp_valid_out <= 1'b1;
				disp_data_out  <= link_rx_data_in[7:0];
			end else if (link_rx_valid_in && link_rx_data_in[7:5] == `BCS_ST_RADIO) begin
				rx_tx_q <= link_rx_data_in[1];
				rx_on_q <= link_rx_data_in[0];
			end
		end
	end

	// Volume stepping on button edges, only while the console holds control.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			vol_q <= 3'h3;
			up_q  <= 1'b0;
			dn_q  <= 1'b0;
		end else begin
			up_q <= btn_in.vol_up;
			dn_q <= btn_in.vol_down;
			if (lk_q == bcs_pkg::BCS_LK_UP) begin
				if (btn_in.vol_up && !up_q && vol_q != 3'h5) begin
					vol_q <= vol_q + 3'h1;
				end else if (btn_in.vol_down && !dn_q && vol_q != 3'h0) begin
					vol_q <= vol_q - 3'h1;
				end
			end
		end
	end

	// Volume lamps as a bar; the bottom lamp blinks while on-channel.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ind_out.vol <= 5'h0;
		end else begin
			ind_out.vol <= 5'((6'h1 << vol_q) - 6'h1);
			if (rx_on_q) begin
				ind_out.vol[0] <= blink_q;
			end
		end
	end

	// Outgoing words: hello, then any control that differs from what was sent.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			link_tx_valid_out <= 1'b0;
			link_tx_data_out  <= 8'h0;
			sent_vol_q        <= 3'h7;
			sent_mon_q        <= 1'b0;
			sent_ptt_q        <= 1'b0;
		end else if (link_tx_valid_out) begin
			if (link_tx_ready_in) begin
				link_tx_valid_out <= 1'b0;
			end
		end else if (lk_q == bcs_pkg::BCS_LK_HELLO && retry_q == 16'h0) begin
			link_tx_valid_out <= 1'b1;
			link_tx_data_out  <= family_q ? `BCS_HELLO_A : `BCS_HELLO_B;
			sent_vol_q        <= 3'h7;
			sent_mon_q        <= 1'b0;
			sent_ptt_q        <= 1'b0;
		end else if (lk_q == bcs_pkg::BCS_LK_UP) begin
			if (sent_ptt_q != btn_in.ptt) begin
				link_tx_valid_out <= 1'b1;
				link_tx_data_out  <= {`BCS_CMD_PTT, 4'h0, btn_in.ptt};
				sent_ptt_q        <= btn_in.ptt;
			end else if (sent_mon_q != mon_now) begin
				link_tx_valid_out <= 1'b1;
				link_tx_data_out  <= {`BCS_CMD_MON, 4'h0, mon_now};
				sent_mon_q        <= mon_now;
			end else if (sent_vol_q != vol_q) begin
				link_tx_valid_out <= 1'b1;
				link_tx_data_out  <= {`BCS_CMD_VOL, 2'h0, vol_q};
				sent_vol_q        <= vol_q;
			end
		end
	end

	// AXI4-Lite write: address and data latched in either order.
	logic       aw_have_q, w_have_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_q         <= 8'h0;
			w_q          <= 32'h0;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			ctrl_q       <= `BCS_CTRL_RESET;
			comp_q       <= `BCS_COMP_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (aw_have_q && w_have_q) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case ({aw_q[7:2], 2'h0})
					`BCS_OFF_CTRL: begin
						if (ws_q[0]) begin
							ctrl_q <= w_q[1:0];
						end
					end
					`BCS_OFF_COMP: begin
						if (ws_q[0]) begin
							comp_q[7:0] <= w_q[7:0];
						end
						if (ws_q[1]) begin
							comp_q[11:8] <= w_q[11:8];
						end
					end
					`BCS_OFF_STATUS, `BCS_OFF_CURRENT: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read: one cycle to the answer; unmapped reads return an error.
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case ({s_axi_araddr[7:2], 2'h0})
				`BCS_OFF_CTRL:    s_axi_rdata <= {30'h0, ctrl_q};
				`BCS_OFF_COMP:    s_axi_rdata <= {20'h0, comp_q};
				`BCS_OFF_STATUS:  s_axi_rdata <= {12'h0, rx_on_q, rx_tx_q, family_q, radio_on,
					1'b0, vol_q, lk_q, id_now, 1'b0, chg_q};
				`BCS_OFF_CURRENT: s_axi_rdata <= {20'h0, charge_ma_out};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* testbench/bcs_radio_model.sv */
// Behavioural portable radio facing the console serial link.
// Assumes one console word per valid/ready handshake and a bench that paces its controls.
`timescale 1ns/1ps
module bcs_radio_model #(
	parameter logic [7:0] HELLO = 8'ha1
) (
	// Clock and reset.
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	// Console to radio.
	input  wire logic       word_valid_in,
	input  wire logic [7:0] word_in,
	output logic            ready_out,
	// Radio to console.
	output logic            rx_valid_out,
	output logic [8:0]      rx_data_out,
	// Bench controls.
	input  wire logic       stall_in,
	input  wire logic [1:0] stat_in,
	input  wire logic       char_valid_in,
	input  wire logic [7:0] char_in
);
	logic [7:0] log_q[$];
	logic       ack_q;
	logic [1:0] stat_q;

	// Ready drops while the bench asks for a stall, to test held words.
	assign ready_out = !stall_in;

	// Every accepted word is logged for the bench to compare in order.
	always @(posedge clock_in) begin
		if (word_valid_in && ready_out)
			log_q.push_back(word_in);
	end

	// Hellos of the other family stay unanswered, as on a real radio.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
			stat_q <= 2'h0;
			rx_valid_out <= 1'b0;
			rx_data_out <= 9'h000;
		end else begin
			ack_q <= word_valid_in && ready_out && word_in == HELLO;
			rx_valid_out <= 1'b1;
			if (ack_q)
				rx_data_out <= 9'h05a;
			else if (stat_q != stat_in) begin
				stat_q <= stat_in;
				rx_data_out <= {4'h4, 3'h0, stat_in};
			end else if (char_valid_in)
				rx_data_out <= {1'b1, char_in};
			else begin
				rx_valid_out <= 1'b0;
				rx_data_out <= ~rx_data_out; // Idle data keeps moving.
			end
		end
	end
endmodule

/* testbench/bcs_top_asserts.sv */
// Checker for the battery charge supervisor, bound to its top module.
// Assumes the sense codes of the package header and a single clock domain.
`timescale 1ns/1ps
module bcs_top_asserts (
	// Clock and reset.
	input wire logic              clock_in,
	input wire logic              rst_n_in,
	// Senses, link, echo, charge and lamps.
	input wire logic [7:0]        id_code_in,
	input wire logic [7:0]        temp_code_in,
	input wire logic              link_tx_valid_out,
	input wire logic [7:0]        link_tx_data_out,
	input wire logic              link_tx_ready_in,
	input wire logic              link_rx_valid_in,
	input wire logic [8:0]        link_rx_data_in,
	input wire logic              disp_valid_out,
	input wire logic [7:0]        disp_data_out,
	input wire logic [11:0]       charge_ma_out,
	input wire bcs_pkg::bcs_ind_t ind_out,
	// Bus handshakes.
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic       bad;
	logic [2:0] bad_cnt_q;
	logic       disp_req_q;
	logic [7:0] rx_byte_q;

	// A pack is unusable when hot or when its code falls in no window.
	assign bad = temp_code_in >= 8'h90 || !((id_code_in >= 8'h38 && id_code_in <= 8'h48)
		|| (id_code_in >= 8'h60 && id_code_in <= 8'h70)
		|| (id_code_in >= 8'h88 && id_code_in <= 8'h98));

	// Counting unusable cycles gives the outputs four cycles to follow the senses.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || !bad)
			bad_cnt_q <= 3'h0;
		else if (bad_cnt_q != 3'h7)
			bad_cnt_q <= bad_cnt_q + 3'h1;
	end

	// Display words seen on the link, for the echo check.
	always_ff @(posedge clock_in) begin
		disp_req_q <= rst_n_in && link_rx_valid_in && link_rx_data_in[8];
		rx_byte_q <= link_rx_data_in[7:0];
	end

	no_charge_a: assert property (bad_cnt_q >= 3'h4 |-> charge_ma_out == 12'h000
		&& !ind_out.red && !ind_out.green) else $error("charge while pack unusable");
	lamp_excl_a: assert property (ind_out.red |-> !ind_out.green)
		else $error("charging and complete lamps both lit");
	red_current_a: assert property (ind_out.red |-> charge_ma_out != 12'h000)
		else $error("charging lamp without current");
	disp_echo_a: assert property (disp_req_q |-> disp_valid_out && disp_data_out == rx_byte_q)
		else $error("display word not echoed");
	disp_cause_a: assert property (disp_valid_out |-> disp_req_q)
		else $error("echo without display word");
	tx_hold_a: assert property (link_tx_valid_out && !link_tx_ready_in |=>
		link_tx_valid_out && $stable(link_tx_data_out)) else $error("link word dropped");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule

bind bcs_top bcs_top_asserts chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.id_code_in(id_code_in), .temp_code_in(temp_code_in),
	.link_tx_valid_out(link_tx_valid_out), .link_tx_data_out(link_tx_data_out),
	.link_tx_ready_in(link_tx_ready_in), .link_rx_valid_in(link_rx_valid_in),
	.link_rx_data_in(link_rx_data_in), .disp_valid_out(disp_valid_out),
	.disp_data_out(disp_data_out), .charge_ma_out(charge_ma_out), .ind_out(ind_out),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

/* testbench/tb_top.sv */
// Self-checking bench for the battery charge supervisor.
// Assumes shortened timers: 20 cycles a half second, six halves of fast charge.
`timescale 1ns/1ps
module tb_top;
	logic              clock_in = 1'b0;
	logic              rst_n_in = 1'b0;
	logic [7:0]        id_code_in = 8'h00, temp_code_in = 8'h50, pwr_code_in = 8'h00;
	logic              mic_line_in = 1'b0;
	bcs_pkg::bcs_btn_t btn_in = '0;
	logic              link_tx_valid_out, link_tx_ready_in, link_rx_valid_in, disp_valid_out;
	logic [7:0]        link_tx_data_out, disp_data_out, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [8:0]        link_rx_data_in;
	logic [11:0]       charge_ma_out;
	bcs_pkg::bcs_ind_t ind_out;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, stall = 1'b0, chv = 1'b0, lv;
	logic [1:0]        s_axi_bresp, s_axi_rresp, stat = 2'h0;
	logic [7:0]        ch = 8'h00;
	int                error_cnt = 0, num_checks = 0, i, tg;
	logic [7:0]        ids [5] = '{8'h38, 8'h68, 8'h98, 8'h99, 8'h20};
	logic [1:0]        cls [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};

	// Free-running 100 MHz clock.
	always #5 clock_in = ~clock_in;

	bcs_top #(.HALF_SEC_CYC(20), .FAST_HALVES(6)) dut_u (.*);
	bcs_radio_model radio_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.word_valid_in(link_tx_valid_out), .word_in(link_tx_data_out),
		.ready_out(link_tx_ready_in), .rx_valid_out(link_rx_valid_in),
		.rx_data_out(link_rx_data_in), .stall_in(stall), .stat_in(stat),
		.char_valid_in(chv), .char_in(ch));

	task automatic wrap_up;
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// A wait that uses up its bound counts as a mismatch and ends the run.
	task automatic lim(input int n, input int max);
		if (n >= max) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// Write: address and data offered together, each released once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_in);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		lim(n, 50);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
		int n;
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_in);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		lim(n, 50);
		chk(s_axi_rdata & m, e);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	// Senses move together; the charge outputs follow them within two cycles.
	task automatic put(input logic [7:0] id, t, p, input logic [11:0] ma, input logic r, g);
		@(posedge clock_in);
		id_code_in <= id;
		temp_code_in <= t;
		pwr_code_in <= p;
		cyc(5);
		chk(charge_ma_out, ma);
		chk(ind_out.red, r);
		chk(ind_out.green, g);
	endtask
	task automatic word(input logic [7:0] e);
		int n;
		for (n = 0; n < 12000 && radio_u.log_q.size() == 0; n++)
			@(posedge clock_in);
		lim(n, 12000);
		chk(radio_u.log_q.pop_front(), e);
	endtask
	task automatic btn(input logic [4:0] m);
		@(posedge clock_in);
		btn_in <= m;
	endtask

	// Main sequence.
	initial begin
		cyc(3);
		rst_n_in <= 1'b1;
		rd(8'h00, 32'hffffffff, 32'h3, 2'h0);
		rd(8'h04, 32'hffffffff, 32'hc8, 2'h0);
		wr(8'h04, 32'hfa, 2'h0);
		rd(8'h04, 32'hfff, 32'hfa, 2'h0);
		wr(8'h08, 32'hffffffff, 2'h0);
		rd(8'h08, 32'h1f, 32'h10, 2'h0);
		wr(8'h10, 32'h1, 2'h2);
		rd(8'h10, 32'hffffffff, 32'h0, 2'h2);
		for (i = 0; i < 5; i++) begin
			put(ids[i], 8'h50, 8'h00, cls[i] != 2'h0 ? 12'h320 : 12'h000, cls[i] != 2'h0, 1'b0);
			rd(8'h08, 32'hc0, {24'h0, cls[i], 6'h0}, 2'h0);
			put(8'h00, 8'h50, 8'h00, 12'h000, 1'b0, 1'b0);
		end
		put(8'h40, 8'h50, 8'h00, 12'h320, 1'b1, 1'b0);
		cyc(60);
		chk(charge_ma_out, 12'h320);
		cyc(100);
		put(8'h40, 8'h55, 8'h00, 12'h064, 1'b0, 1'b1);
		put(8'h40, 8'h95, 8'h00, 12'h000, 1'b0, 1'b0);
		put(8'h40, 8'h55, 8'h00, 12'h064, 1'b0, 1'b1);
		put(8'h00, 8'h55, 8'h00, 12'h000, 1'b0, 1'b0);
		put(8'h40, 8'h30, 8'h00, 12'h064, 1'b1, 1'b0);
		put(8'h40, 8'h74, 8'h00, 12'h064, 1'b1, 1'b0);
		put(8'h40, 8'h50, 8'h00, 12'h320, 1'b1, 1'b0);
		put(8'h40, 8'h78, 8'h00, 12'h064, 1'b0, 1'b1);
		put(8'h00, 8'h50, 8'h00, 12'h000, 1'b0, 1'b0);
		put(8'h40, 8'h50, 8'hc0, 12'h41a, 1'b1, 1'b0);
		word(8'hb1);
		put(8'h40, 8'h50, 8'hbe, 12'h320, 1'b1, 1'b0);
		mic_line_in <= 1'b1;
		put(8'h40, 8'h50, 8'hbf, 12'h41a, 1'b1, 1'b0);
		word(8'ha1);
		word(8'h23);
		cyc(5);
		rd(8'h08, 32'hf00, 32'h800, 2'h0);
		rd(8'h0c, 32'hfff, 32'h41a, 2'h0);
		chk(ind_out.vol, 5'h07);
		btn(5'h01);
		word(8'h61);
		btn(5'h00);
		word(8'h60);
		for (i = 0; i < 2; i++) begin
			btn(i == 0 ? 5'h04 : 5'h02);
			word(8'h41);
			btn(5'h00);
			word(8'h40);
		end
		stall <= 1'b1;
		btn(5'h10);
		cyc(4);
		btn(5'h00);
		stall <= 1'b0;
		word(8'h24);
		chk(ind_out.vol, 5'h0f);
		btn(5'h08);
		cyc(2);
		btn(5'h00);
		word(8'h23);
		chk(ind_out.vol, 5'h07);
		stat <= 2'h2;
		cyc(6);
		chk(charge_ma_out, 12'h5dc);
		stat <= 2'h0;
		cyc(6);
		chk(charge_ma_out, 12'h41a);
		ch <= 8'h4b;
		chv <= 1'b1;
		cyc(1);
		chv <= 1'b0;
		stat <= 2'h1;
		cyc(2);
		chk(disp_valid_out, 1'b1);
		chk(disp_data_out, 8'h4b);
		cyc(4);
		lv = ind_out.vol[0];
		tg = 0;
		repeat (100) begin
			@(posedge clock_in);
			if (ind_out.vol[0] !== lv)
				tg++;
			lv = ind_out.vol[0];
		end
		chk(tg >= 2, 1);
		wrap_up();
	end
endmodule
